// [axis_feedback_position_config.sv]
// Four-axis feedback counting, compensation and display block
`timescale 1ns/100ps
module axis_feedback_position_config (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic [axis_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [axis_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  input  wire logic [axis_pkg::AXES-1:0]     QUAD_A,
  input  wire logic [axis_pkg::AXES-1:0]     QUAD_B,
  input  wire logic [axis_pkg::AXES-1:0]     MARKER,
  input  wire logic                          PROBE,
  output logic [axis_pkg::AXES-1:0]          SHOWN,
  output logic [axis_pkg::AXES-1:0]          BLINK,
  output logic                               PROBE_EVENT
);
  import axis_pkg::*;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  axis_cfg_type       cfg       [AXES];
  logic [15:0]        cres      [AXES];
  logic [15:0]        dres      [AXES];
  logic signed [31:0] scale     [AXES];
  logic signed [31:0] prog_in   [AXES];
  logic signed [31:0] lower     [AXES];
  logic signed [31:0] upper     [AXES];
  logic signed [31:0] pos       [AXES];
  logic signed [31:0] comp      [AXES];
  logic signed [31:0] own_disp  [AXES];
  logic signed [31:0] shown_val [AXES];
  logic signed [31:0] probe_val [AXES];
  logic signed [31:0] cp        [AXES][COMP_POINTS];
  logic signed [31:0] ce        [AXES][COMP_POINTS];
  logic               arm       [AXES];
  logic               homed     [AXES];
  logic [AXES-1:0]    comb_err;
  logic [ADDR_W-1:0]  waddr;
  logic [31:0]        wdata;
  logic               wfull;
  logic               probe_q;
  logic [1:0]         sel;

  wire logic [1:0] w_axis    = waddr[AXIS_LSB +: 2];
  wire logic [7:0] w_ofs     = waddr[7:0];
  wire logic       w_axis_ok = ~|waddr[ADDR_W-1:AXIS_LSB+2];
  wire logic       w_comp    = (w_ofs >= OFS_COMP) && (w_ofs < OFS_COMP_END);
  wire logic [7:0] w_rel     = w_ofs - OFS_COMP;
  wire logic [3:0] w_pt      = w_rel[COMP_IDX_LSB +: 4];
  wire axis_cfg_type w_cfg   = axis_cfg_type'(wdata[CFG_W-1:0]);
  wire logic [15:0] w_res    = wdata[RES_W-1:0];
  wire logic       w_hi      = |wdata[31:RES_W];
  wire logic       cfg_bad   = w_cfg.comp_points > 4'(COMP_POINTS);
  // zero steps or coarser than display refused
  wire logic cres_bad = w_hi || (w_res == 16'h0000) || (w_res > dres[w_axis]);
  wire logic dres_bad = w_hi || (w_res < cres[w_axis]);
  wire logic w_map = w_comp || (w_ofs == OFS_CFG) || (w_ofs == OFS_CRES)
                  || (w_ofs == OFS_DRES) || (w_ofs == OFS_SCALE)
                  || (w_ofs == OFS_LOWER) || (w_ofs == OFS_UPPER)
                  || (w_ofs == OFS_CTRL) || (w_ofs == OFS_PROG_IN);
  wire logic w_ok = w_axis_ok && w_map && wfull
                  && !((w_ofs == OFS_CFG) && cfg_bad)
                  && !((w_ofs == OFS_CRES) && cres_bad)
                  && !((w_ofs == OFS_DRES) && dres_bad);
  wire logic do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire logic w_en     = do_write && w_ok;
  wire logic [15:0] dres_w = dres[w_axis];

  wire logic [1:0] r_axis    = S_AXI_ARADDR[AXIS_LSB +: 2];
  wire logic [7:0] r_ofs     = S_AXI_ARADDR[7:0];
  wire logic       r_axis_ok = ~|S_AXI_ARADDR[ADDR_W-1:AXIS_LSB+2];
  wire logic       r_comp    = (r_ofs >= OFS_COMP) && (r_ofs < OFS_COMP_END);
  wire logic [7:0] r_rel     = r_ofs - OFS_COMP;
  wire logic [3:0] r_pt      = r_rel[COMP_IDX_LSB +: 4];
  wire logic signed [63:0] prog_prod =
    64'(prog_in[r_axis]) * 64'(scale[r_axis]);
  wire logic [31:0] prog_out = prog_prod[SCALE_FRAC +: 32];
  logic [31:0] rd_data;
  logic        rd_ok;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = r_axis_ok;
    if (r_comp) begin
      rd_data = r_rel[COMP_ERR_BIT] ? ce[r_axis][r_pt] : cp[r_axis][r_pt];
    end else begin
      case (r_ofs)
        OFS_CFG:      rd_data = {12'h000, cfg[r_axis]};
        OFS_CRES:     rd_data = {16'h0000, cres[r_axis]};
        OFS_DRES:     rd_data = {16'h0000, dres[r_axis]};
        OFS_SCALE:    rd_data = scale[r_axis];
        OFS_LOWER:    rd_data = lower[r_axis];
        OFS_UPPER:    rd_data = upper[r_axis];
        OFS_CTRL:     rd_data = {29'h0000_0000, comb_err[r_axis],
                                 homed[r_axis], arm[r_axis]};
        OFS_POS:      rd_data = comp[r_axis];
        OFS_SHOWN:    rd_data = shown_val[r_axis];
        OFS_PROBE:    rd_data = probe_val[r_axis];
        OFS_PROG_IN:  rd_data = prog_in[r_axis];
        OFS_PROG_OUT: rd_data = prog_out;
        default:      rd_ok = 1'b0;
      endcase
    end
  end

  // One write and one read in flight; partial strobes are refused
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= RESP_OKAY;
      S_AXI_RDATA   <= 32'h0000_0000;
      waddr         <= '0;
      wdata         <= 32'h0000_0000;
      wfull         <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        waddr         <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        wdata        <= S_AXI_WDATA;
        wfull        <= (S_AXI_WSTRB == STRB_ALL);
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_data;
        S_AXI_RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // settings held per axis, read by counter and display
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int a = 0; a < AXES; a++) begin
        cfg[a]     <= (a == AXES - 1) ? CFG_RESET_ROTARY : CFG_RESET_LINEAR;
        cres[a]    <= RES_RESET;
        dres[a]    <= RES_RESET;
        scale[a]   <= SCALE_RESET;
        prog_in[a] <= 32'sh0;
        lower[a]   <= LOWER_RESET;
        upper[a]   <= UPPER_RESET;
        for (int k = 0; k < COMP_POINTS; k++) begin
          cp[a][k] <= 32'sh0;
          ce[a][k] <= 32'sh0;
        end
      end
    end else if (w_en) begin
      if (w_comp) begin
        if (w_rel[COMP_ERR_BIT]) begin
          ce[w_axis][w_pt] <= wdata;
        end else begin
          cp[w_axis][w_pt] <= wdata;
        end
      end else begin
        case (w_ofs)
          OFS_CFG:     cfg[w_axis]     <= w_cfg;
          OFS_CRES:    cres[w_axis]    <= w_res;
          OFS_DRES:    dres[w_axis]    <= w_res;
          OFS_SCALE:   scale[w_axis]   <= wdata;
          OFS_LOWER:   lower[w_axis]   <= wdata;
          OFS_UPPER:   upper[w_axis]   <= wdata;
          OFS_PROG_IN: prog_in[w_axis] <= wdata;
          default:     ;
        endcase
      end
    end
  end

  for (genvar i = 0; i < AXES; i++) begin : g_axis
    logic a_q;
    logic b_q;
    wire logic a_edge  = QUAD_A[i] ^ a_q;
    wire logic b_edge  = QUAD_B[i] ^ b_q;
    // x2 counts A edges only, x4 both
    wire logic step    = (a_edge ^ b_edge) && (a_edge || cfg[i].edge_x4);
    wire logic up      = (a_edge ? (QUAD_A[i] != QUAD_B[i])
                                 : (QUAD_A[i] == QUAD_B[i]))
                         ^ cfg[i].dir_negative;
    // sine input steps by interpolation factor
    wire logic [4:0] amt = cfg[i].wave_sine ? INTERP_FACTOR[cfg[i].interp]
                                            : STEP_ONE;
    wire logic signed [31:0] amt32 = $signed({27'h000_0000, amt});
    wire logic home_wr = w_en && !w_comp && (w_ofs == OFS_CTRL)
                         && (w_axis == 2'(i)) && wdata[0];
    wire logic catch   = arm[i] && MARKER[i];

    always_ff @(posedge CLK) begin
      if (RST) begin
        a_q      <= 1'b0;
        b_q      <= 1'b0;
        pos[i]   <= 32'sh0;
        arm[i]   <= 1'b0;
        homed[i] <= 1'b0;
      end else begin
        a_q <= QUAD_A[i];
        b_q <= QUAD_B[i];
        // armed marker zeroes count, marks homed
        if (catch) begin
          pos[i]   <= 32'sh0;
          homed[i] <= 1'b1;
        end else if (step) begin
          pos[i] <= up ? pos[i] + amt32 : pos[i] - amt32;
        end
        arm[i] <= home_wr || (arm[i] && !MARKER[i]);
      end
    end

    property p_count_up;
      step && !catch && !cfg[i].wave_sine && !cfg[i].dir_negative
        && a_edge && (QUAD_A[i] != QUAD_B[i])
        |=> pos[i] == $past(pos[i]) + 32'sh1;
    endproperty
    a_count_up: assert property (p_count_up)
      else $error("forward edge did not add one");

    property p_x2_ignores_b;
      !cfg[i].edge_x4 && b_edge && !a_edge && !catch |=> $stable(pos[i]);
    endproperty
    a_x2_ignores_b: assert property (p_x2_ignores_b)
      else $error("x2 mode counted a B edge");

    sequence s_marker_caught;
      arm[i] && MARKER[i];
    endsequence
    sequence s_zero_homed;
      (pos[i] == 32'sh0) && homed[i];
    endsequence
    property p_home;
      s_marker_caught |=> s_zero_homed ##1 homed[i] && !arm[i];
    endproperty
    a_home: assert property (p_home)
      else $error("marker did not home the axis");

    property p_rotary_no_blink;
      (sel == 2'(i)) && cfg[i].rotary |=> !BLINK[i];
    endproperty
    a_rotary_no_blink: assert property (p_rotary_no_blink)
      else $error("rotary axis blinking");

    property p_blink_high;
      (sel == 2'(i)) && !cfg[i].rotary && (own_disp[i] > upper[i])
        |=> BLINK[i] ##1 $stable(BLINK[i]);
    endproperty
    a_blink_high: assert property (p_blink_high)
      else $error("axis beyond upper limit not blinking");

    property p_probe_snap;
      $rose(PROBE) |=> PROBE_EVENT && (probe_val[i] == $past(own_disp[i]));
    endproperty
    a_probe_snap: assert property (p_probe_snap)
      else $error("probe snapshot missing or wrong");

    property p_rotary_operand;
      (sel == 2'(i)) && (cfg[i].combine == COMB_ADD)
        && cfg[cfg[i].first_axis].rotary |=> comb_err[i];
    endproperty
    a_rotary_operand: assert property (p_rotary_operand)
      else $error("rotary operand accepted");
  end

  // Engine visits one axis per clock, so each stage lags by up to 4 cycles and the shown value by up to 12
  wire axis_cfg_type c_sel = cfg[sel];
  wire logic signed [31:0] p_sel = pos[sel];
  wire logic [3:0] npts = c_sel.comp_points;
  logic [COMP_POINTS-1:0] ge;
  logic [3:0]             idx;
  logic [3:0]             lo;
  logic signed [31:0]     span;
  logic signed [63:0]     num;
  logic signed [31:0]     err;
  logic signed [31:0]     sv;

  for (genvar k = 0; k < COMP_POINTS; k++) begin : g_pt
    assign ge[k] = (4'(k) < npts) && (p_sel >= cp[sel][k]);
  end

  always_comb begin
    idx = 4'h0;
    for (int k = 0; k < COMP_POINTS; k++) begin
      idx = idx + {3'h0, ge[k]};
    end
  end

  always_comb begin
    lo   = idx - 4'h1;
    span = 32'sh0;
    num  = 64'sh0;
    err  = 32'sh0;
    if (npts == 4'h0) begin
      err = 32'sh0;
    end else if (idx == 4'h0) begin
      err = ce[sel][0];
    end else if (idx >= npts) begin
      err = ce[sel][npts - 4'h1];
    end else begin
      // linear between neighbours; zero span takes lower error
      span = cp[sel][idx] - cp[sel][lo];
      num  = 64'(ce[sel][idx] - ce[sel][lo]) * 64'(p_sel - cp[sel][lo]);
      err  = (span == 32'sh0) ? ce[sel][lo]
                              : ce[sel][lo] + 32'(num / 64'(span));
    end
  end

  // Finest steps, truncated toward zero at display resolution
  wire logic signed [48:0] fin    = comp[sel] * $signed({1'b0, cres[sel]});
  wire logic signed [48:0] dres49 = $signed({33'h0_0000_0000, dres[sel]});
  wire logic signed [48:0] quant  = fin - (fin % dres49);
  // rotary operand falls back to own reading
  wire logic rot_op  = cfg[c_sel.first_axis].rotary
                    || cfg[c_sel.second_axis].rotary;
  wire logic comb_on = (c_sel.combine == COMB_ADD)
                    || (c_sel.combine == COMB_SUB);
  // diameter only when allowed, chosen and linear
  wire logic diam_on = c_sel.diam_allowed && c_sel.diam_sel && !c_sel.rotary;

  always_comb begin
    sv = diam_on ? own_disp[sel] <<< 1 : own_disp[sel];
    if (comb_on && !rot_op) begin
      sv = (c_sel.combine == COMB_ADD)
         ? own_disp[c_sel.first_axis] + own_disp[c_sel.second_axis]
         : own_disp[c_sel.first_axis] - own_disp[c_sel.second_axis];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sel      <= 2'h0;
      comb_err <= '0;
      BLINK    <= '0;
      SHOWN    <= '0;
      for (int a = 0; a < AXES; a++) begin
        comp[a]      <= 32'sh0;
        own_disp[a]  <= 32'sh0;
        shown_val[a] <= 32'sh0;
      end
    end else begin
      sel            <= sel + 2'h1;
      comp[sel]      <= p_sel + err;
      own_disp[sel]  <= quant[31:0];
      shown_val[sel] <= sv;
      comb_err[sel]  <= comb_on && rot_op;
      // limits skipped on rotary; flag outside
      BLINK[sel]     <= !c_sel.rotary
                        && ((own_disp[sel] < lower[sel])
                        || (own_disp[sel] > upper[sel]));
      for (int a = 0; a < AXES; a++) begin
        SHOWN[a] <= cfg[a].visible;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      probe_q     <= 1'b0;
      PROBE_EVENT <= 1'b0;
      for (int a = 0; a < AXES; a++) begin
        probe_val[a] <= 32'sh0;
      end
    end else begin
      probe_q     <= PROBE;
      PROBE_EVENT <= PROBE && !probe_q;
      if (PROBE && !probe_q) begin
        for (int a = 0; a < AXES; a++) begin
          probe_val[a] <= own_disp[a];
        end
      end
    end
  end

  property p_dres_refused;
    do_write && w_axis_ok && !w_comp && (w_ofs == OFS_DRES) && dres_bad
      |=> (dres_w == $past(dres_w)) && (S_AXI_BRESP == RESP_SLVERR)
          && S_AXI_BVALID;
  endproperty
  a_dres_refused: assert property (p_dres_refused)
    else $error("too fine display resolution accepted");
endmodule : axis_feedback_position_config

// [axis_pkg.sv]
// Constants, field layouts and types for the four-axis position block
package axis_pkg;
  localparam int AXES            = 4;
  localparam int COMP_POINTS     = 10;
  localparam int ADDR_W          = 12;
  localparam int AXIS_LSB        = 8;
  localparam int SCALE_FRAC      = 16;
  localparam int CFG_W           = 20;
  localparam int COMP_ERR_BIT    = 2;
  localparam int COMP_IDX_LSB    = 3;
  localparam int RES_W           = 16;
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_CRES     = 8'h04;
  localparam logic [7:0] OFS_DRES     = 8'h08;
  localparam logic [7:0] OFS_SCALE    = 8'h0C;
  localparam logic [7:0] OFS_LOWER    = 8'h10;
  localparam logic [7:0] OFS_UPPER    = 8'h14;
  localparam logic [7:0] OFS_CTRL     = 8'h18;
  localparam logic [7:0] OFS_POS      = 8'h1C;
  localparam logic [7:0] OFS_SHOWN    = 8'h20;
  localparam logic [7:0] OFS_PROBE    = 8'h24;
  localparam logic [7:0] OFS_PROG_IN  = 8'h28;
  localparam logic [7:0] OFS_PROG_OUT = 8'h2C;
  localparam logic [7:0] OFS_COMP     = 8'h40;
  localparam logic [7:0] OFS_COMP_END = 8'h90;
  // Resolutions count finest steps: 0.0001 mm or 0.000005 inch
  localparam logic [15:0] RES_RESET   = 16'h0032;
  localparam logic [31:0] SCALE_RESET = 32'h0001_0000;
  localparam logic signed [31:0] LOWER_RESET = 32'shC465_3601;
  localparam logic signed [31:0] UPPER_RESET = 32'sh3B9A_C9FF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_ALL    = 4'hF;
  localparam logic [4:0] STEP_ONE    = 5'h01;
  localparam logic [4:0] INTERP_FACTOR [4] = '{5'h05, 5'h0A, 5'h14, 5'h19};

  typedef enum logic [1:0] {COMB_NONE, COMB_ADD, COMB_SUB} combine_type;

  typedef struct packed {
    logic [3:0]  comp_points;
    logic [1:0]  interp;
    logic        edge_x4;
    logic        diam_sel;
    logic        diam_allowed;
    logic        dir_negative;
    logic        unit_imperial;
    logic        rotary;
    logic        wave_sine;
    logic        visible;
    logic [1:0]  second_axis;
    logic [1:0]  first_axis;
    combine_type combine;
  } axis_cfg_type;

  localparam axis_cfg_type CFG_RESET_LINEAR = 20'h0_2840;
  localparam axis_cfg_type CFG_RESET_ROTARY = 20'h0_2140;
endpackage : axis_pkg

// [scale_model.sv]
// Quadrature scale model with a marker output for four axes
`timescale 1ns/100ps
module scale_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step_req,
  input  wire logic [1:0] step_axis,
  input  wire logic       step_up,
  input  wire logic [3:0] mark_req,
  output logic      [3:0] quad_a,
  output logic      [3:0] quad_b,
  output logic      [3:0] marker
);
  logic [1:0] phase [4];
  always_ff @(posedge clk) begin
    if (rst) begin
      phase  <= '{default: 2'h0};
      marker <= 4'h0;
    end else begin
      if (step_req) begin
        phase[step_axis] <= step_up ? phase[step_axis] + 2'h1
                                    : phase[step_axis] - 2'h1;
      end
      marker <= mark_req;
    end
  end
  // Only one line changes per step, never both
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign quad_a[i] = phase[i][0] ^ phase[i][1];
    assign quad_b[i] = phase[i][1];
  end
endmodule : scale_model

// [axis_feedback_position_config_tb.sv]
// Register-level bench for the axis position block
`timescale 1ns/100ps
module axis_feedback_position_config_tb;
  import axis_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = STRB_ALL;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        probe = 1'b0;
  logic        step_req = 1'b0;
  logic [1:0]  step_axis = 2'h0;
  logic        step_up = 1'b1;
  logic [3:0]  mark_req = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, pev;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, cnt, exp;
  logic [3:0]  qa, qb, mk, shown, blink;
  int          bad_count = 0;
  int          num_checks = 0;
  axis_feedback_position_config u_dut (
    .CLK(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .QUAD_A(qa), .QUAD_B(qb), .MARKER(mk), .PROBE(probe),
    .SHOWN(shown), .BLINK(blink), .PROBE_EVENT(pev)
  );
  scale_model u_scale (
    .clk(clk), .rst(rst), .step_req(step_req), .step_axis(step_axis),
    .step_up(step_up), .mark_req(mark_req),
    .quad_a(qa), .quad_b(qb), .marker(mk)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [11:0] ad(input logic [1:0] ax,
                                     input logic [7:0] o);
    return {2'b00, ax, o};
  endfunction : ad
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk($sformatf("bresp %h", a), bresp, er);
      end
    end
    if (!done) begin
      chk("write handshake", done, 1'b1);
      conclude();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk($sformatf("rdata %h", a), rdata, e);
        chk($sformatf("rresp %h", a), rresp, er);
      end
    end
    if (!done) begin
      chk("read handshake", done, 1'b1);
      conclude();
    end
  endtask : rd
  // Settling wait covers the refresh, display and limit latencies
  task automatic stp(input logic [1:0] ax, input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      step_axis <= ax;
      step_up <= up;
      step_req <= 1'b1;
      @(posedge clk);
      step_req <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (16) @(posedge clk);
  endtask : stp
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ad(0, OFS_CFG), CFG_RESET_LINEAR, RESP_OKAY);
    rd(ad(3, OFS_CFG), CFG_RESET_ROTARY, RESP_OKAY);
    rd(ad(2, OFS_CRES), RES_RESET, RESP_OKAY);
    rd(ad(0, 8'h30), 32'h0, RESP_SLVERR);
    chk("shown", shown, 4'hF);
    $display("end reset test");
    wr(ad(0, OFS_CRES), 32'h1, RESP_OKAY);
    wr(ad(0, OFS_DRES), 32'h1, RESP_OKAY);
    wr(ad(0, OFS_DRES), 32'h0, RESP_SLVERR);
    rd(ad(0, OFS_DRES), 32'h1, RESP_OKAY);
    stp(0, 1'b1, 4);
    rd(ad(0, OFS_POS), 32'h4, RESP_OKAY);
    wr(ad(0, OFS_CFG), 32'h02C40, RESP_OKAY);
    stp(0, 1'b1, 2);
    rd(ad(0, OFS_POS), 32'h2, RESP_OKAY);
    wr(ad(0, OFS_CFG), 32'h00840, RESP_OKAY);
    stp(0, 1'b1, 4);
    rd(ad(0, OFS_POS), 32'h4, RESP_OKAY);
    exp = 32'h4;
    for (int i = 0; i < 4; i++) begin
      wr(ad(0, OFS_CFG), 32'h028C0 | (i << 14), RESP_OKAY);
      stp(0, 1'b1, 1);
      exp = exp + INTERP_FACTOR[i];
      rd(ad(0, OFS_POS), exp, RESP_OKAY);
    end
    $display("end counting test");
    wr(ad(0, OFS_CFG), CFG_RESET_LINEAR, RESP_OKAY);
    wr(ad(0, OFS_CTRL), 32'h1, RESP_OKAY);
    rd(ad(0, OFS_CTRL), 32'h1, RESP_OKAY);
    @(posedge clk);
    mark_req <= 4'h1;
    @(posedge clk);
    mark_req <= 4'h0;
    repeat (16) @(posedge clk);
    rd(ad(0, OFS_POS), 32'h0, RESP_OKAY);
    rd(ad(0, OFS_CTRL), 32'h2, RESP_OKAY);
    // Home point first with zero error, slope 5 percent
    wr(ad(0, OFS_COMP + 8'h08), 32'd40, RESP_OKAY);
    wr(ad(0, OFS_COMP + 8'h0C), 32'd2, RESP_OKAY);
    wr(ad(0, OFS_CFG), 32'h22840, RESP_OKAY);
    stp(0, 1'b1, 20);
    rd(ad(0, OFS_POS), 32'd21, RESP_OKAY);
    stp(0, 1'b1, 30);
    rd(ad(0, OFS_POS), 32'd52, RESP_OKAY);
    rd(ad(0, OFS_SHOWN), 32'd52, RESP_OKAY);
    $display("end compensation test");
    @(posedge clk);
    probe <= 1'b1;
    cnt = 32'h0;
    repeat (6) begin
      @(posedge clk);
      cnt = cnt + pev;
    end
    probe <= 1'b0;
    chk("probe event", cnt, 32'h1);
    rd(ad(0, OFS_PROBE), 32'd52, RESP_OKAY);
    wr(ad(0, OFS_CFG), 32'h23840, RESP_OKAY);
    // Round-robin engine needs up to 4 cycles to show a new setting
    repeat (8) @(posedge clk);
    rd(ad(0, OFS_SHOWN), 32'd104, RESP_OKAY);
    wr(ad(0, OFS_UPPER), 32'd50, RESP_OKAY);
    wr(ad(3, OFS_LOWER), 32'd10, RESP_OKAY);
    repeat (16) @(posedge clk);
    chk("blink", blink, 4'h1);
    wr(ad(0, OFS_UPPER), UPPER_RESET, RESP_OKAY);
    repeat (16) @(posedge clk);
    chk("blink", blink, 4'h0);
    $display("end probe and limit test");
    wr(ad(0, OFS_CFG), 32'h22840, RESP_OKAY);
    wr(ad(1, OFS_CFG), 32'h02841, RESP_OKAY);
    repeat (8) @(posedge clk);
    rd(ad(1, OFS_SHOWN), 32'd104, RESP_OKAY);
    wr(ad(1, OFS_CFG), 32'h02852, RESP_OKAY);
    repeat (8) @(posedge clk);
    rd(ad(1, OFS_SHOWN), 32'd52, RESP_OKAY);
    wr(ad(1, OFS_CFG), 32'h0284D, RESP_OKAY);
    repeat (8) @(posedge clk);
    rd(ad(1, OFS_SHOWN), 32'h0, RESP_OKAY);
    rd(ad(1, OFS_CTRL), 32'h4, RESP_OKAY);
    wr(ad(2, OFS_CFG), 32'h02A00, RESP_OKAY);
    rd(ad(2, OFS_CFG), 32'h02A00, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("shown", shown, 4'hB);
    wr(ad(2, OFS_SCALE), 32'h0002_0000, RESP_OKAY);
    wr(ad(2, OFS_PROG_IN), 32'd100, RESP_OKAY);
    rd(ad(2, OFS_PROG_OUT), 32'd200, RESP_OKAY);
    $display("end display test");
    conclude();
  end
endmodule : axis_feedback_position_config_tb
